// [cssu_pkg.sv]
/*
  Constants and types for the clock source select and start-up block.
  Assumes a single 125 MHz system clock and fuse values held stable by the programming logic.
*/
package cssu_pkg;
  typedef enum logic [2:0] {
    CSSU_SRC_CRYSTAL,
    CSSU_SRC_LF_CRYSTAL,
    CSSU_SRC_RC,
    CSSU_SRC_EXTERNAL,
    CSSU_SRC_RESERVED
  } cssu_src_t;

  typedef enum logic [1:0] {
    CSSU_ST_RESET_CK,
    CSSU_ST_RESET_WDOG,
    CSSU_ST_RUN,
    CSSU_ST_WAKE
  } cssu_state_t;

  localparam logic [3:0] CSSU_SEL_RC = 4'h2;
  localparam logic [3:0] CSSU_SEL_EXT = 4'h0;
  localparam logic [3:0] CSSU_SEL_LF_LO = 4'h6;
  localparam logic [3:0] CSSU_SEL_LF_HI = 4'h7;
  localparam int CSSU_SEL_XTAL_BIT = 3;
  localparam logic [1:0] CSSU_SUT_SHORT = 2'h0;
  localparam logic [1:0] CSSU_SUT_4K = 2'h1;
  localparam logic [1:0] CSSU_SUT_64K = 2'h2;
  localparam logic [1:0] CSSU_SUT_RSVD = 2'h3;
  localparam logic [3:0] CSSU_DEFAULT_SEL = CSSU_SEL_RC;
  localparam logic [1:0] CSSU_DEFAULT_SUT = CSSU_SUT_64K;
  localparam int CSSU_WAKE_CK_RC = 6;
  localparam int CSSU_RESET_CK = 14;
  localparam int CSSU_WDOG_4K = 4096;
  localparam int CSSU_WDOG_64K = 65536;
  localparam int CSSU_CNT_W = 17;
  localparam int CSSU_PRESC_W = 4;
  localparam logic [3:0] CSSU_PRESC_DIV8 = 4'h3;
  localparam logic [3:0] CSSU_PRESC_DIV1 = 4'h0;
  localparam int CSSU_TRIM_W = 8;
endpackage

// [cssu_clock_ctrl.sv]
/*
  Clock source decode, start-up timing and glitch-free domain gating.
  Assumes the watchdog oscillator tick arrives asynchronously as a level toggle, and that
  source clock edges arrive as a tick pulse on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module cssu_clock_ctrl (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] clock_source_select_fuses_i,
  input wire logic [1:0] startup_time_fuses_i,
  input wire logic divide_by_eight_fuse_i,
  input wire logic [cssu_pkg::CSSU_TRIM_W-1:0] factory_trim_i,
  input wire logic trim_wr_i,
  input wire logic [cssu_pkg::CSSU_TRIM_W-1:0] trim_wdata_i,
  input wire logic wdog_osc_toggle_i,
  input wire logic src_tick_i,
  input wire logic wake_req_i,
  input wire logic core_run_req_i,
  input wire logic periph_run_req_i,
  input wire logic async_run_req_i,
  input wire logic conv_run_req_i,
  input wire logic ext_irq_async_i,
  input wire logic serial_start_async_i,
  output logic core_clock_en_o,
  output logic program_memory_clock_en_o,
  output logic peripheral_clock_en_o,
  output logic async_timer_clock_en_o,
  output logic converter_clock_en_o,
  output logic core_halted_o,
  output logic wake_event_o,
  output logic [cssu_pkg::CSSU_TRIM_W-1:0] rc_trim_register_o,
  output logic [cssu_pkg::CSSU_PRESC_W-1:0] prescaler_sel_o,
  output cssu_pkg::cssu_src_t clock_source_o,
  output logic config_invalid_o,
  output logic startup_busy_o
);
  import cssu_pkg::*;

  logic [3:0] sel_q;
  logic [1:0] sut_q;
  logic div8_q;
  logic cfg_valid_q;
  logic [CSSU_TRIM_W-1:0] trim_q;
  logic [CSSU_PRESC_W-1:0] presc_q;
  cssu_state_t state_q;
  logic [CSSU_CNT_W-1:0] cnt_q;
  logic wd_s1_q, wd_s2_q, wd_s3_q;
  logic core_en_q, periph_en_q, async_en_q, conv_en_q;
  logic [3:0] sel_s1_q, sel_s2_q;
  logic [1:0] sut_s1_q, sut_s2_q;
  logic div8_s1_q, div8_s2_q;
  logic [CSSU_TRIM_W-1:0] ftrim_s1_q, ftrim_s2_q;

  // Fuse and factory trim lines come from the nonvolatile array, outside this
  // clock's domain, so two flip-flops settle them before any logic reads them.
  // No reset here on purpose: the stages settle while reset is held, so the
  // first edge after release already samples clean values.
  always_ff @(posedge ref_clk_i) begin
    sel_s1_q <= clock_source_select_fuses_i;
    sel_s2_q <= sel_s1_q;
    sut_s1_q <= startup_time_fuses_i;
    sut_s2_q <= sut_s1_q;
    div8_s1_q <= divide_by_eight_fuse_i;
    div8_s2_q <= div8_s1_q;
    ftrim_s1_q <= factory_trim_i;
    ftrim_s2_q <= ftrim_s1_q;
  end

  // Fuses sampled in the first cycle after reset release, then frozen
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_q <= CSSU_DEFAULT_SEL;
      sut_q <= CSSU_DEFAULT_SUT;
      div8_q <= 1'b0;
      cfg_valid_q <= 1'b0;
    end else if (!cfg_valid_q) begin
      sel_q <= sel_s2_q;
      sut_q <= sut_s2_q;
      div8_q <= ~div8_s2_q; // Fuse reads 0 when programmed
      cfg_valid_q <= 1'b1;
    end
  end

  cssu_src_t src_w;
  wire is_xtal_w = sel_q[CSSU_SEL_XTAL_BIT];
  wire is_lf_w = (sel_q == CSSU_SEL_LF_LO) || (sel_q == CSSU_SEL_LF_HI);
  assign src_w = is_xtal_w ? CSSU_SRC_CRYSTAL :
                 is_lf_w ? CSSU_SRC_LF_CRYSTAL :
                 (sel_q == CSSU_SEL_RC) ? CSSU_SRC_RC :
                 (sel_q == CSSU_SEL_EXT) ? CSSU_SRC_EXTERNAL : CSSU_SRC_RESERVED;
  wire invalid_w = (src_w == CSSU_SRC_RESERVED) ||
                   (src_w == CSSU_SRC_RC && sut_q == CSSU_SUT_RSVD);

  // Watchdog oscillator edges, synchronised before use
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_s1_q <= 1'b0;
      wd_s2_q <= 1'b0;
      wd_s3_q <= 1'b0;
    end else begin
      wd_s1_q <= wdog_osc_toggle_i;
      wd_s2_q <= wd_s1_q;
      wd_s3_q <= wd_s2_q;
    end
  end
  wire wd_tick_w = wd_s2_q ^ wd_s3_q;

  // Only the RC timing is modelled; other sources reuse its counts
  wire [CSSU_CNT_W-1:0] wdog_len_w = (sut_q == CSSU_SUT_4K) ? CSSU_CNT_W'(CSSU_WDOG_4K) :
                                     CSSU_CNT_W'(CSSU_WDOG_64K);
  wire need_wdog_w = (sut_q == CSSU_SUT_4K) || (sut_q == CSSU_SUT_64K);
  wire cnt_done_w = (cnt_q == '0);
  wire [CSSU_CNT_W-1:0] cnt_dec_w = cnt_q - CSSU_CNT_W'(1);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= CSSU_ST_RESET_CK;
      cnt_q <= CSSU_CNT_W'(CSSU_RESET_CK);
    end else if (!cfg_valid_q || invalid_w) begin
      state_q <= CSSU_ST_RESET_CK;
      cnt_q <= CSSU_CNT_W'(CSSU_RESET_CK);
    end else begin
      unique case (state_q)
        CSSU_ST_RESET_CK: begin
          if (src_tick_i && !cnt_done_w) begin
            cnt_q <= cnt_dec_w;
          end else if (cnt_done_w) begin
            state_q <= need_wdog_w ? CSSU_ST_RESET_WDOG : CSSU_ST_RUN;
            cnt_q <= wdog_len_w;
          end
        end
        CSSU_ST_RESET_WDOG: begin
          if (wd_tick_w && !cnt_done_w) begin
            cnt_q <= cnt_dec_w;
          end else if (cnt_done_w) begin
            state_q <= CSSU_ST_RUN;
          end
        end
        CSSU_ST_RUN: begin
          if (wake_req_i) begin
            state_q <= CSSU_ST_WAKE;
            cnt_q <= CSSU_CNT_W'(CSSU_WAKE_CK_RC);
          end
        end
        CSSU_ST_WAKE: begin
          if (src_tick_i && !cnt_done_w) begin
            cnt_q <= cnt_dec_w;
          end else if (cnt_done_w) begin
            state_q <= CSSU_ST_RUN;
          end
        end
      endcase
    end
  end
  wire running_w = (state_q == CSSU_ST_RUN);

  // Trim loads factory value once, then software may rewrite it
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trim_q <= '0;
      presc_q <= CSSU_PRESC_DIV1;
    end else if (!cfg_valid_q) begin
      trim_q <= ftrim_s2_q;
      presc_q <= div8_s2_q ? CSSU_PRESC_DIV1 : CSSU_PRESC_DIV8;
    end else if (trim_wr_i) begin
      trim_q <= trim_wdata_i;
    end
  end

  // One gating term per domain: bit 0 core, 1 peripheral, 2 async timer, 3 converter
  logic [3:0] dom_req_w;
  logic [3:0] dom_ok_w;
  logic [3:0] dom_next_w;
  assign dom_req_w = {conv_run_req_i, async_run_req_i, periph_run_req_i, core_run_req_i};
  // The async timer domain may run once the fuses are in; the rest wait for start-up
  assign dom_ok_w = {running_w, cfg_valid_q, running_w, running_w};
  for (genvar d = 0; d < $bits(dom_req_w); d++) begin : g_dom
    assign dom_next_w[d] = dom_ok_w[d] & dom_req_w[d];
  end

  // Enables change only on a register edge; the downstream clock gate latches them
  // while its clock is low, so no truncated pulse can appear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_en_q <= 1'b0;
      periph_en_q <= 1'b0;
      async_en_q <= 1'b0;
      conv_en_q <= 1'b0;
    end else begin
      core_en_q <= dom_next_w[0];
      periph_en_q <= dom_next_w[1];
      async_en_q <= dom_next_w[2];
      conv_en_q <= dom_next_w[3];
    end
  end

  assign core_clock_en_o = core_en_q;
  assign program_memory_clock_en_o = core_en_q;
  assign peripheral_clock_en_o = periph_en_q;
  assign async_timer_clock_en_o = async_en_q;
  assign converter_clock_en_o = conv_en_q;
  assign core_halted_o = ~core_en_q;
  // Pure combinational path: must work with every clock stopped
  assign wake_event_o = ext_irq_async_i | serial_start_async_i;
  assign rc_trim_register_o = trim_q;
  assign prescaler_sel_o = presc_q;
  assign clock_source_o = src_w;
  assign config_invalid_o = cfg_valid_q & invalid_w;
  assign startup_busy_o = ~running_w;
endmodule // cssu_clock_ctrl
`default_nettype wire

// [cssu_properties.sv]
/* Port-level checks of the clock source select and start-up block.
   Bound to cssu_clock_ctrl from the bench; sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module cssu_properties
  import cssu_pkg::*;
(
  input wire logic ref_clk_i, rst_n_i, src_tick_i, divide_by_eight_fuse_i,
  input wire logic ext_irq_async_i, serial_start_async_i,
  input wire logic periph_run_req_i, async_run_req_i, conv_run_req_i,
  input wire logic [cssu_pkg::CSSU_TRIM_W-1:0] factory_trim_i, rc_trim_register_o,
  input wire logic [cssu_pkg::CSSU_PRESC_W-1:0] prescaler_sel_o,
  input wire logic core_clock_en_o, program_memory_clock_en_o, core_halted_o,
  input wire logic peripheral_clock_en_o, async_timer_clock_en_o, converter_clock_en_o,
  input wire logic wake_event_o, config_invalid_o, startup_busy_o,
  input wire cssu_pkg::cssu_src_t clock_source_o
);
  logic [1:0] up_q;
  logic [4:0] tk_q;
  // Ticks seen while busy; saturates so long start-ups cannot wrap
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_q <= 2'h0;
      tk_q <= 5'h00;
    end else begin
      up_q <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
      tk_q <= !startup_busy_o ? 5'h00 : tk_q + {4'h0, src_tick_i & (tk_q != 5'h1f)};
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_running;
    !startup_busy_o ##1 !startup_busy_o;
  endsequence
  a_pm_follows_core: assert property (program_memory_clock_en_o == core_clock_en_o)
    else $error("program memory enable differs from core enable");
  a_busy_halts_core: assert property (startup_busy_o && $past(startup_busy_o) |-> core_halted_o && !core_clock_en_o)
    else $error("core clock runs during start-up");
  a_async_wake: assert property (wake_event_o == (ext_irq_async_i | serial_start_async_i))
    else $error("async wake event wrong");
  a_periph_gate: assert property (s_running |-> peripheral_clock_en_o == $past(periph_run_req_i))
    else $error("peripheral enable does not follow request");
  a_async_domain: assert property (s_running |-> async_timer_clock_en_o == $past(async_run_req_i))
    else $error("async timer enable does not follow request");
  a_conv_domain: assert property (s_running |-> converter_clock_en_o == $past(conv_run_req_i))
    else $error("converter enable does not follow request");
  a_invalid_stalls: assert property (config_invalid_o |-> startup_busy_o)
    else $error("invalid configuration left start-up");
  a_fuses_held: assert property (up_q == 2'h3 |-> $stable(clock_source_o) && $stable(prescaler_sel_o))
    else $error("sampled configuration changed");
  a_reset_load: assert property (up_q == 2'h1 |-> rc_trim_register_o == factory_trim_i && prescaler_sel_o == (divide_by_eight_fuse_i ? CSSU_PRESC_DIV1 : CSSU_PRESC_DIV8))
    else $error("trim or prescaler not loaded at reset");
  a_wake_ticks: assert property ($fell(startup_busy_o) |-> tk_q >= 5'h06)
    else $error("start-up ended before six source ticks");
endmodule // cssu_properties
`default_nettype wire

// [cssu_osc_model.sv]
/* Stand-in for the oscillators: source clock ticks and the watchdog oscillator.
   Runs free on the system clock; outputs change 1 ns after its edge. */
`timescale 1ns/1ns
`default_nettype none
module cssu_osc_model #(
  parameter int TICK_DIV = 4,
  parameter int WD_DIV = 2
) (
  input wire logic ref_clk_i,
  output logic src_tick_o,
  output logic wdog_toggle_o
);
  int tc = 0;
  int wc = 0;
  initial src_tick_o = 1'b0;
  initial wdog_toggle_o = 1'b0;
  always @(posedge ref_clk_i) begin
    #1;
    tc = (tc + 1) % TICK_DIV;
    wc = (wc + 1) % WD_DIV;
    src_tick_o <= (tc == 0);
    // Separate oscillator, independent of the selected source
    if (wc == 0) wdog_toggle_o <= ~wdog_toggle_o;
  end
endmodule // cssu_osc_model
`default_nettype wire

// [tb_top.sv]
/* Self-checking bench for cssu_clock_ctrl with oscillator model and checker.
   Source ticks every 4 cycles, watchdog toggles every 2. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cssu_pkg::*;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, trim_wr_i = 1'b0, wake_req_i = 1'b0;
  logic ext_irq_async_i = 1'b0, serial_start_async_i = 1'b0, divide_by_eight_fuse_i = 1'b0;
  logic core_run_req_i = 1'b1, periph_run_req_i = 1'b1, async_run_req_i = 1'b1;
  logic conv_run_req_i = 1'b1, src_tick_i, wdog_osc_toggle_i;
  logic [3:0] clock_source_select_fuses_i = 4'h2;
  logic [1:0] startup_time_fuses_i = 2'h0;
  logic [7:0] factory_trim_i = 8'ha5, trim_wdata_i = 8'h3c, rc_trim_register_o;
  logic core_clock_en_o, program_memory_clock_en_o, peripheral_clock_en_o, core_halted_o;
  logic async_timer_clock_en_o, converter_clock_en_o, wake_event_o, config_invalid_o;
  logic startup_busy_o;
  logic [3:0] prescaler_sel_o;
  cssu_src_t clock_source_o;
  int error_cnt = 0, checks_done = 0, n;
  // Requests core,periph,async,conv beside enables core,pm,periph,async,conv
  logic [8:0] rows [6] = '{9'h000, 9'h118, 9'h0a5, 9'h15a, 9'h021, 9'h1ff};
  cssu_clock_ctrl dut_u (.*);
  cssu_osc_model osc_u (.ref_clk_i, .src_tick_o(src_tick_i), .wdog_toggle_o(wdog_osc_toggle_i));
  initial forever #4 ref_clk_i = ~ref_clk_i;
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [2:0] exp_src(input logic [3:0] c);
    if (c[3]) return CSSU_SRC_CRYSTAL;
    if (c[3:1] == 3'h3) return CSSU_SRC_LF_CRYSTAL;
    if (c == 4'h2) return CSSU_SRC_RC;
    if (c == 4'h0) return CSSU_SRC_EXTERNAL;
    return CSSU_SRC_RESERVED;
  endfunction
  task automatic boot(input logic [3:0] s, input logic [1:0] t);
    rst_n_i = 1'b0;
    clock_source_select_fuses_i = s;
    startup_time_fuses_i = t;
    cyc(8);
    rst_n_i = 1'b1;
    cyc(2);
  endtask
  task automatic settle();
    n = 0;
    while (startup_busy_o !== 1'b0 && n < 20000) begin
      cyc(1);
      n++;
    end
  endtask
  initial begin
    for (int c = 0; c < 16; c++) begin
      boot(c[3:0], 2'h0);
      chk(clock_source_o, exp_src(c[3:0]));
      chk(config_invalid_o, exp_src(c[3:0]) == CSSU_SRC_RESERVED);
    end
    boot(4'h2, 2'h3);
    chk(config_invalid_o, 1'b1);
    boot(4'h2, 2'h2);
    chk({prescaler_sel_o, rc_trim_register_o}, {CSSU_PRESC_DIV8, 8'ha5});
    cyc(3000);
    chk(startup_busy_o, 1'b1);
    divide_by_eight_fuse_i = 1'b1;
    boot(4'h2, 2'h0);
    chk(prescaler_sel_o, CSSU_PRESC_DIV1);
    settle();
    chk(n > 40 && n < 200, 1'b1);
    boot(4'h2, 2'h1);
    settle();
    chk(n > 8000 && n < 20000, 1'b1);
    foreach (rows[i]) begin
      {core_run_req_i, periph_run_req_i, async_run_req_i, conv_run_req_i} = rows[i][8:5];
      cyc(2);
      chk({core_clock_en_o, program_memory_clock_en_o, peripheral_clock_en_o,
        async_timer_clock_en_o, converter_clock_en_o}, rows[i][4:0]);
    end
    trim_wr_i = 1'b1;
    cyc(1);
    trim_wr_i = 1'b0;
    cyc(1);
    chk(rc_trim_register_o, 8'h3c);
    core_run_req_i = 1'b0;
    cyc(2);
    chk(core_halted_o, 1'b1);
    wake_req_i = 1'b1;
    cyc(1);
    wake_req_i = 1'b0;
    core_run_req_i = 1'b1;
    cyc(2);
    chk(startup_busy_o, 1'b1);
    settle();
    chk(n >= 14 && n < 40, 1'b1);
    for (int k = 1; k < 4; k++) begin
      {ext_irq_async_i, serial_start_async_i} = k[1:0];
      cyc(1);
      chk(wake_event_o, 1'b1);
    end
    end_of_test();
  end
  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end
endmodule // tb_top
bind cssu_clock_ctrl cssu_properties chk_u (.*);
`default_nettype wire
